// [rtl/itr_out_mux.sv]
`timescale 1ns/10ps
`default_nettype none
module itr_out_mux
#(
  parameter int WIDTH = 9
)
(
  // select and sources
  input wire logic test_en_i,
  input wire logic [WIDTH-1:0] func_i,
  input wire logic [WIDTH-1:0] drive_i,
  // pins
  output logic [WIDTH-1:0] pin_o
);
  // test value replaces functional value while test mode is on
  assign pin_o = test_en_i ? drive_i : func_i;
endmodule : itr_out_mux
`default_nettype wire

// [rtl/itr_pkg.sv]
package itr_pkg;
  // register word addresses, byte offsets as printed
  localparam logic [11:0] ITR_ADDR_CONTROL = 12'h0e00;
  localparam logic [11:0] ITR_ADDR_OBSERVE = 12'h0e04;
  localparam logic [11:0] ITR_ADDR_DRIVE = 12'h0e08;
  // field positions
  localparam int ITR_TEST_EN_BIT = 0;
  localparam int ITR_OBS_WIDTH = 10;
  localparam int ITR_DRV_WIDTH = 9;
  localparam int ITR_DRV_CLK_ACTIVE = 0;
  localparam int ITR_DRV_LP_ACK = 1;
  localparam int ITR_DRV_REQ_IF0 = 2;
  localparam int ITR_DRV_REQ_IF1 = 3;
  localparam int ITR_DRV_IRQ_ALL = 4;
  localparam int ITR_DRV_IRQ_IF0 = 5;
  localparam int ITR_DRV_IRQ_IF1 = 6;
  localparam int ITR_DRV_CORR_IF0 = 7;
  localparam int ITR_DRV_CORR_IF1 = 8;
  // values after reset
  localparam logic ITR_CONTROL_RESET = 1'b0;
  localparam logic [8:0] ITR_DRIVE_RESET = 9'h000;
  localparam logic [31:0] ITR_READ_ZERO = 32'h0000_0000;
  // synchroniser depth for pin inputs
  localparam int ITR_SYNC_STAGES = 3;
endpackage : itr_pkg

// [rtl/itr_regs.sv]
// Notes on behaviour
// - control bit 0 enables test logic; control resets to zero
// - control bits 31:1 read as zero; software writes them zero
// - when test disabled, observe and drive ignore writes, read zero
// - observe bits 0..9 return live levels of listed input pins
// - observe register reset value follows the tie-off inputs; here the synchronised levels reset to zero
// - drive bits 0..6 each set one output pin
// - drive bits 7,8 drive correction irqs, only with correction support
// - registers decode at 0xE00 control, 0xE04 observe, 0xE08 drive
// - registers unreachable while controller held in reset
// - interface 1 bits work only in dual-interface builds
`timescale 1ns/10ps
`default_nettype none
module itr_regs
#(
  parameter bit DUAL_IF = 1'b1,
  parameter bit HAS_CORRECTION = 1'b1
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // observed pins
  input wire logic lp_request_i,
  input wire logic shared_bus_select_i,
  input wire logic shared_bus_grant_if0_i,
  input wire logic shared_bus_backoff_if0_i,
  input wire logic busclk_sync_tie_if0_i,
  input wire logic memclk_sync_tie_if0_i,
  input wire logic shared_bus_grant_if1_i,
  input wire logic shared_bus_backoff_if1_i,
  input wire logic busclk_sync_tie_if1_i,
  input wire logic memclk_sync_tie_if1_i,
  // functional values of controllable outputs
  input wire logic [8:0] func_out_i,
  // controllable outputs
  output logic clk_active_o,
  output logic lp_ack_o,
  output logic shared_bus_request_if0_o,
  output logic shared_bus_request_if1_o,
  output logic combined_irq_o,
  output logic iface0_irq_o,
  output logic iface1_irq_o,
  output logic iface0_correction_irq_o,
  output logic iface1_correction_irq_o,
  // test mode state
  output logic test_en_o
);
  logic test_en;
  logic [8:0] drive;
  logic [31:0] rdata;
  logic [9:0] raw_pins;
  logic [9:0] obs_live;
  logic [8:0] drive_mask;
  logic [8:0] pins;

  // pin bundle in observe bit order
  assign raw_pins = {memclk_sync_tie_if1_i, busclk_sync_tie_if1_i,
    shared_bus_backoff_if1_i, shared_bus_grant_if1_i,
    memclk_sync_tie_if0_i, busclk_sync_tie_if0_i,
    shared_bus_backoff_if0_i, shared_bus_grant_if0_i,
    shared_bus_select_i, lp_request_i};

  // pins come from outside the clock domain, so filter each
  genvar g;
  generate
    for (g = 0; g < itr_pkg::ITR_OBS_WIDTH; g++)
    begin : g_sync
      itr_sync u_sync
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(raw_pins[g]),
        .level_o(obs_live[g])
      );
    end
  endgenerate

  // absent interface 1 / correction bits are not implemented
  assign drive_mask = {HAS_CORRECTION & DUAL_IF, HAS_CORRECTION,
    DUAL_IF, 2'b11, DUAL_IF, 3'b111};

  // address decode; whole block in reset answers nothing
  logic hit_ctl;
  logic hit_obs;
  logic hit_drv;
  assign hit_ctl = (addr_i == itr_pkg::ITR_ADDR_CONTROL);
  assign hit_obs = (addr_i == itr_pkg::ITR_ADDR_OBSERVE);
  assign hit_drv = (addr_i == itr_pkg::ITR_ADDR_DRIVE);

  // next read word; drive is write-only, so it reads zero
  logic [31:0] next_rdata;
  assign next_rdata = hit_ctl ? {31'h0000_0000, test_en}
    : (hit_obs && test_en)
      ? {22'h00_0000, obs_live & {DUAL_IF, DUAL_IF, DUAL_IF, DUAL_IF,
        6'h3f}}
      : itr_pkg::ITR_READ_ZERO;

  // control and drive registers; reset blocks all access
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      test_en <= itr_pkg::ITR_CONTROL_RESET;
      drive <= itr_pkg::ITR_DRIVE_RESET;
    end
    else if (ce_i && wr_i)
    begin
      if (hit_ctl)
        test_en <= wdata_i[itr_pkg::ITR_TEST_EN_BIT];
      if (hit_drv && test_en)
        drive <= wdata_i[8:0] & drive_mask;
    end
  end

  // read data stands one cycle after the strobe, then clears
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata <= itr_pkg::ITR_READ_ZERO;
    else if (ce_i)
      rdata <= rd_i ? next_rdata : itr_pkg::ITR_READ_ZERO;
  end
  assign rdata_o = rdata;
  assign test_en_o = test_en;

  // output override; functional path restored when disabled
  logic [8:0] func_masked;
  assign func_masked = func_out_i & drive_mask;
  itr_out_mux #(.WIDTH(itr_pkg::ITR_DRV_WIDTH)) u_mux
  (
    .test_en_i(test_en),
    .func_i(func_masked),
    .drive_i(drive),
    .pin_o(pins)
  );

  // pin mapping of drive bits
  assign clk_active_o = pins[itr_pkg::ITR_DRV_CLK_ACTIVE];
  assign lp_ack_o = pins[itr_pkg::ITR_DRV_LP_ACK];
  assign shared_bus_request_if0_o = pins[itr_pkg::ITR_DRV_REQ_IF0];
  assign shared_bus_request_if1_o = pins[itr_pkg::ITR_DRV_REQ_IF1];
  assign combined_irq_o = pins[itr_pkg::ITR_DRV_IRQ_ALL];
  assign iface0_irq_o = pins[itr_pkg::ITR_DRV_IRQ_IF0];
  assign iface1_irq_o = pins[itr_pkg::ITR_DRV_IRQ_IF1];
  assign iface0_correction_irq_o = pins[itr_pkg::ITR_DRV_CORR_IF0];
  assign iface1_correction_irq_o = pins[itr_pkg::ITR_DRV_CORR_IF1];

  // checks
  property p_read_latency;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_i && hit_ctl) |=> (rdata_o == {31'h0, $past(test_en)});
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("control read data wrong");

  property p_upper_zero;
    @(posedge clk_i) disable iff (rst_i)
    rdata_o[31:10] == 22'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");

  property p_disabled_zero;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_i && !test_en && (hit_obs || hit_drv)) |=> rdata_o == 32'h0;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero)
    else $error("read nonzero while test disabled");

  property p_write_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_i && hit_drv && !test_en) |=> $stable(drive);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("drive written while test disabled");

  property p_observe;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_i && hit_obs && test_en) |=>
      rdata_o[5:0] == $past(obs_live[5:0]);
  endproperty
  a_observe: assert property (p_observe)
    else $error("observe data wrong");

  property p_drive_write;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_i && hit_drv && test_en) |=>
      lp_ack_o == $past(wdata_i[1]);
  endproperty
  a_drive_write: assert property (p_drive_write)
    else $error("drive bit not on pin");

  property p_override;
    @(posedge clk_i) disable iff (rst_i)
    !test_en |-> pins == (func_out_i & drive_mask);
  endproperty
  a_override: assert property (p_override)
    else $error("functional value not restored");

  property p_if1_absent;
    @(posedge clk_i) disable iff (rst_i)
    !DUAL_IF |-> (rdata_o[9:6] == 4'h0 && !iface1_irq_o);
  endproperty
  a_if1_absent: assert property (p_if1_absent)
    else $error("interface 1 bit active in single build");

  property p_one_cycle;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !rd_i) |=> rdata_o == 32'h0;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("read data held too long");

  // control write lands next cycle
  property p_ctl_write;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_i && hit_ctl) |=> test_en == $past(wdata_i[0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not taken");

  // undefined control bits never leak into read data
  property p_ctl_upper;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_i && hit_ctl) |=> rdata_o[31:1] == 31'h0;
  endproperty
  a_ctl_upper: assert property (p_ctl_upper)
    else $error("control upper bits not zero");

  // interface 1 observe bits follow pins only in dual builds
  property p_if1_observe;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_i && hit_obs && test_en) |=>
      rdata_o[9:6] == ($past(obs_live[9:6]) & {4{DUAL_IF}});
  endproperty
  a_if1_observe: assert property (p_if1_observe)
    else $error("interface 1 observe bits wrong");

  // pin order checked apart from the package field map
  property p_pin_map;
    @(posedge clk_i) disable iff (rst_i)
    test_en |-> {iface1_correction_irq_o, iface0_correction_irq_o,
      iface1_irq_o, iface0_irq_o, combined_irq_o, shared_bus_request_if1_o,
      shared_bus_request_if0_o, lp_ack_o, clk_active_o} == drive;
  endproperty
  a_pin_map: assert property (p_pin_map)
    else $error("drive bit on wrong pin");

  // correction pins stay low without correction support
  property p_corr_absent;
    @(posedge clk_i) disable iff (rst_i)
    !HAS_CORRECTION |-> !iface0_correction_irq_o && !iface1_correction_irq_o;
  endproperty
  a_corr_absent: assert property (p_corr_absent)
    else $error("correction pin active without support");

  // drive and unmapped words read zero
  property p_unmapped_read;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_i && !hit_ctl && !hit_obs) |=> rdata_o == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("write-only or unmapped word read nonzero");

  // only the drive word reaches the drive register
  property p_unmapped_write;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_i && !hit_drv) |=> $stable(drive);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("drive changed by another word");

  // first edge after reset sees reset values
  property p_reset_values;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (!test_en && drive == itr_pkg::ITR_DRIVE_RESET &&
      rdata_o == 32'h0);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("state not cleared by reset");

  // low enable freezes every register
  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> ($stable(test_en) && $stable(drive) && $stable(rdata_o));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while enable low");

  c_enable: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(test_en));
  c_obs_read: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_i && hit_obs && test_en);
  c_drive: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_i && hit_drv && test_en);
  c_exit: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(test_en) && lp_ack_o == 1'b0);
  c_freeze: cover property (@(posedge clk_i) disable iff (rst_i)
    !ce_i && wr_i && hit_drv);
endmodule : itr_regs
`default_nettype wire

// [rtl/itr_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module itr_sync
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  // last stage index; the last two stages vote on a change
  localparam int LAST = itr_pkg::ITR_SYNC_STAGES - 1;
  logic [LAST:0] stage;
  logic level;

  // three stage flops and a level flop; change accepted when the last two stages agree
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage <= '0;
      level <= 1'b0;
    end
    else if (ce_i)
    begin
      stage <= {stage[LAST-1:0], pin_i};
      if (stage[LAST-1] == stage[LAST])
        level <= stage[LAST];
    end
  end

  assign level_o = level;
endmodule : itr_sync
`default_nettype wire

// [verification/itr_sw_model.sv]
`timescale 1ns/10ps
`default_nettype none
module itr_sw_model
(
  // clock
  input wire logic clk_i,
  // register port, master side
  output logic [11:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i
);
  // idle bus at time zero
  initial
  begin
    addr_o = 12'h000;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle write; callers keep undefined upper bits zero
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // stale data must not look valid
  endtask : bus_write
  // one-cycle read; data taken in the single cycle it stands
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : bus_read
  // leave test mode with low-power ack high
  task automatic leave_test();
    bus_write(itr_pkg::ITR_ADDR_DRIVE, 32'h0000_0002);
    bus_write(itr_pkg::ITR_ADDR_CONTROL, 32'h0000_0000);
  endtask : leave_test
endmodule : itr_sw_model
`default_nettype wire

// [verification/test_integration_test_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module test_integration_test_regs;
  typedef struct {
    logic [9:0] obs;
    logic [8:0] drv;
    logic [9:0] exp_obs;
    logic [8:0] exp_pins;
  } itr_row_s;
  logic clk_i, rst_i, wr, rd, test_en;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [9:0] obs;
  logic ce;
  logic [8:0] func;
  logic [31:0] rdata_s;
  wire logic [8:0] outs, outs_s;
  int err_count, checks_done;
  itr_row_s rows [4] = '{'{10'h001, 9'h001, 10'h001, 9'h001},
    '{10'h2aa, 9'h155, 10'h2aa, 9'h155}, '{10'h155, 9'h0aa, 10'h155, 9'h0aa},
    '{10'h3ff, 9'h1ff, 10'h3ff, 9'h1ff}};
  itr_sw_model u_itr_sw_model (.clk_i(clk_i), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  itr_regs u_itr_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .lp_request_i(obs[0]), .shared_bus_select_i(obs[1]),
    .shared_bus_grant_if0_i(obs[2]), .shared_bus_backoff_if0_i(obs[3]),
    .busclk_sync_tie_if0_i(obs[4]), .memclk_sync_tie_if0_i(obs[5]),
    .shared_bus_grant_if1_i(obs[6]), .shared_bus_backoff_if1_i(obs[7]),
    .busclk_sync_tie_if1_i(obs[8]), .memclk_sync_tie_if1_i(obs[9]),
    .func_out_i(func), .clk_active_o(outs[0]), .lp_ack_o(outs[1]),
    .shared_bus_request_if0_o(outs[2]), .shared_bus_request_if1_o(outs[3]),
    .combined_irq_o(outs[4]), .iface0_irq_o(outs[5]), .iface1_irq_o(outs[6]),
    .iface0_correction_irq_o(outs[7]), .iface1_correction_irq_o(outs[8]),
    .test_en_o(test_en));
  // single-interface build without correction support
  itr_regs #(.DUAL_IF(1'b0), .HAS_CORRECTION(1'b0)) u_itr_regs_single
    (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_s),
    .lp_request_i(obs[0]), .shared_bus_select_i(obs[1]),
    .shared_bus_grant_if0_i(obs[2]), .shared_bus_backoff_if0_i(obs[3]),
    .busclk_sync_tie_if0_i(obs[4]), .memclk_sync_tie_if0_i(obs[5]),
    .shared_bus_grant_if1_i(obs[6]), .shared_bus_backoff_if1_i(obs[7]),
    .busclk_sync_tie_if1_i(obs[8]), .memclk_sync_tie_if1_i(obs[9]),
    .func_out_i(func), .clk_active_o(outs_s[0]), .lp_ack_o(outs_s[1]),
    .shared_bus_request_if0_o(outs_s[2]),
    .shared_bus_request_if1_o(outs_s[3]), .combined_irq_o(outs_s[4]),
    .iface0_irq_o(outs_s[5]), .iface1_irq_o(outs_s[6]),
    .iface0_correction_irq_o(outs_s[7]), .iface1_correction_irq_o(outs_s[8]),
    .test_en_o());
  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check_word(input string what, input logic [31:0] e,
    input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask : check_word
  task automatic check_pins(input string what, input logic [8:0] e);
    checks_done++;
    if (outs !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, e, outs);
    end
  endtask : check_pins
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // watchdog, run needs well under a thousand cycles
  initial
  begin
    #200_000;
    err_count++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    obs = 10'h000;
    func = 9'h0a5;
    ce = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    obs <= 10'h3ff;
    @(posedge clk_i);
    #1 check_word("test_en", 32'h0, {31'h0, test_en});
    check_pins("pins off", 9'h0a5);
    check_word("pins off single", 32'h0000_0025, {23'h0, outs_s});
    u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_CONTROL, rv);
    check_word("control", 32'h0000_0000, rv);
    repeat (5) @(posedge clk_i);
    u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_OBSERVE, rv);
    check_word("observe off", 32'h0000_0000, rv);
    u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_DRIVE, 32'h0000_01ff);
    u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_CONTROL, 32'h0000_0001);
    #1 check_pins("ignored drive", 9'h000);
    u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_CONTROL, rv);
    check_word("control on", 32'h0000_0001, rv);
    u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_DRIVE, rv);
    check_word("drive read", 32'h0000_0000, rv);
    u_itr_sw_model.bus_read(12'he0c, rv);
    check_word("unmapped", 32'h0000_0000, rv);
    $display("test reset_and_refuse done");
    // table of observe and drive patterns with test on
    foreach (rows[i])
    begin
      @(posedge clk_i);
      obs <= rows[i].obs;
      u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_DRIVE, {23'h0, rows[i].drv});
      #1 check_pins("pins", rows[i].exp_pins);
      check_word("pins single", {23'h0, rows[i].exp_pins & 9'h037},
        {23'h0, outs_s});
      repeat (5) @(posedge clk_i);
      u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_OBSERVE, rv);
      check_word("observe", {22'h00_0000, rows[i].exp_obs}, rv);
      check_word("observe single", {22'h00_0000, rows[i].exp_obs & 10'h03f},
        rdata_s);
    end
    $display("test table done");
    // clock enable low: a drive write must not land
    @(posedge clk_i);
    ce <= 1'b0;
    u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_DRIVE, 32'h0000_0000);
    #1 check_pins("frozen", 9'h1ff);
    @(posedge clk_i);
    ce <= 1'b1;
    $display("test freeze done");
    u_itr_sw_model.leave_test();
    #1 check_pins("pins restored", 9'h0a5);
    $display("test leave done");
    // reset in mid-run with test on and a drive bit set
    u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_CONTROL, 32'h0000_0001);
    u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_DRIVE, 32'h0000_0001);
    #1 check_pins("pins before rst", 9'h001);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    #1 check_word("test_en rst", 32'h0, {31'h0, test_en});
    check_pins("pins rst", 9'h0a5);
    @(posedge clk_i);
    rst_i <= 1'b0;
    u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_CONTROL, rv);
    check_word("control rst", 32'h0000_0000, rv);
    u_itr_sw_model.bus_write(itr_pkg::ITR_ADDR_CONTROL, 32'h0000_0001);
    #1 check_pins("drive rst", 9'h000);
    repeat (5) @(posedge clk_i);
    u_itr_sw_model.bus_read(itr_pkg::ITR_ADDR_OBSERVE, rv);
    check_word("observe rst", 32'h0000_03ff, rv);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule : test_integration_test_regs
`default_nettype wire
